// ==== hs_supply_pkg.sv ====
package hs_supply_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] HIGH_SIDE_CONTROL_OFS     = 8'h28;
    localparam logic [7:0] HIGH_SIDE_STATUS_OFS      = 8'h29;
    localparam logic [7:0] SENSOR_SUPPLY_CONTROL_OFS = 8'h38;
    localparam logic [7:0] REG_RESET                 = 8'h00;

    // ****************************************
    // high_side_control fields
    // ****************************************
    localparam int HSC_OT_IRQ_EN  = 7;
    localparam int HSC_OV_SD_EN   = 6;
    localparam int HSC_CHSEL_LSB  = 4;
    localparam int HSC_MODEN_LSB  = 2;
    localparam int HSC_ENABLE_LSB = 0;

    // ****************************************
    // high_side_status fields
    // ****************************************
    localparam int HSS_OT_COND    = 7;
    localparam int HSS_CLIM_LSB   = 2;
    localparam int HSS_OLOAD_LSB  = 0;

    // ****************************************
    // sensor_supply_control fields
    // ****************************************
    localparam int SSC_OT_IRQ_EN  = 7;
    localparam int SSC_OT_COND    = 6;
    localparam int SSC_REG_ON     = 0;

    localparam int NUM_DRIVERS    = 2;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SLEEP,
        MODE_STOP
    } power_mode_e;

endpackage : hs_supply_pkg

// ==== high_side_and_sensor_supply_ctrl.sv ====
`timescale 1ns/10ps
// Behaviour
// R1: sensor supply runs only in normal mode, off in low-power modes
// R2: supply overtemperature forces regulator off, shown in read-only status bit
// R3: reading supply register clears latched supply overtemperature flag
// R4: after supply overtemperature, only a later register write restores supply
// R5: supply register: irq enable bit 7, condition bit 6, on bit 0
// R6: regulator on bit 0 disables, 1 enables the supply regulator
// R7: each driver gets own open-load bit when current below threshold
// R8: open-load detection inactive while driver off, including pwm off phase
// R9: each driver gets own current-limit status bit
// R10: overtemperature switches both drivers off, latched as interrupt source
// R11: thermal shutdown sets overtemperature bit in high-side status register
// R12: after thermal shutdown, drivers restart only on later control write
// R13: overvoltage with shutdown enable switches both drivers off
// R14: after overvoltage shutdown, drivers restart only on later control write
// R15: drivers may remain enabled in sleep and stop modes
// R16: control register: irq enable bit 7, overvoltage enable bit 6, resets zero
// R17: channel select bit picks pwm channel 0 or 1 per driver
// R18: modulation enable bit applies selected pwm channel per driver
// R19: per-driver enable bit switches driver off or on
// R20: host reaches registers at base plus offset, blocking or non-blocking
// R21: reading high-side status clears latched driver overtemperature flag
// R22: irq raised only while latched flag set and its enable set
module high_side_and_sensor_supply_ctrl (
    input  wire logic                       mclk,                // system clock
    input  wire logic                       reset,               // sync reset, high
    input  wire logic [7:0]                 reg_addr,            // register offset
    input  wire logic                       reg_wr,              // write strobe
    input  wire logic                       reg_rd,              // read strobe
    input  wire logic [7:0]                 reg_wdata,           // write data
    output logic      [7:0]                 reg_rdata,           // read data
    input  wire hs_supply_pkg::power_mode_e power_mode,          // device mode
    input  wire logic [1:0]                 pwm_channel,         // pwm channel levels
    input  wire logic                       supply_overtemp_in,  // supply ot sensor
    input  wire logic                       driver_overtemp_in,  // driver ot sensor
    input  wire logic                       overvoltage_condition, // high voltage
    input  wire logic [1:0]                 open_load_in,        // low current per driver
    input  wire logic [1:0]                 current_limit_in,    // limit per driver
    output logic                            sensor_supply_output, // regulator on
    output logic      [1:0]                 driver_on,           // driver gates
    output logic                            supply_overtemp_irq, // supply irq
    output logic                            driver_overtemp_irq  // driver irq
);

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int SYNC_W = 9;
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [SYNC_W-1:0] nxt_sync1;
    logic [SYNC_W-1:0] nxt_sync2;
    logic              sup_ot;
    logic              drv_ot;
    logic              ov_cond;
    logic [1:0]        pwm_s;
    logic [1:0]        ol_s;
    logic [1:0]        cl_s;

    always_comb begin
        nxt_sync1 = {supply_overtemp_in, driver_overtemp_in, overvoltage_condition,
                     pwm_channel, open_load_in, current_limit_in};
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge mclk) begin
        sync1_ff <= nxt_sync1;
        sync2_ff <= nxt_sync2;
    end

    assign {sup_ot, drv_ot, ov_cond, pwm_s, ol_s, cl_s} = sync2_ff;

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] hsc_ff;
    logic [7:0] nxt_hsc;
    logic       sup_on_ff;
    logic       nxt_sup_on;
    logic       sup_ie_ff;
    logic       nxt_sup_ie;
    logic       sup_flag_ff;
    logic       nxt_sup_flag;
    logic       drv_flag_ff;
    logic       nxt_drv_flag;
    logic       sup_lock_ff;
    logic       nxt_sup_lock;
    logic       drv_lock_ff;
    logic       nxt_drv_lock;
    logic       sup_ot_d_ff;
    logic       nxt_sup_ot_d;
    logic       drv_ot_d_ff;
    logic       nxt_drv_ot_d;
    logic       wr_hsc;
    logic       wr_ssc;
    logic       rd_hss;
    logic       rd_ssc;
    logic       ov_trip;

    assign wr_hsc  = reg_wr && (reg_addr == hs_supply_pkg::HIGH_SIDE_CONTROL_OFS);
    assign wr_ssc  = reg_wr && (reg_addr == hs_supply_pkg::SENSOR_SUPPLY_CONTROL_OFS);
    assign rd_hss  = reg_rd && (reg_addr == hs_supply_pkg::HIGH_SIDE_STATUS_OFS);
    assign rd_ssc  = reg_rd && (reg_addr == hs_supply_pkg::SENSOR_SUPPLY_CONTROL_OFS);
    assign ov_trip = ov_cond && hsc_ff[hs_supply_pkg::HSC_OV_SD_EN];          // R13

    always_comb begin
        nxt_hsc      = hsc_ff;
        nxt_sup_on   = sup_on_ff;
        nxt_sup_ie   = sup_ie_ff;
        nxt_sup_ot_d = sup_ot;
        nxt_drv_ot_d = drv_ot;
        nxt_sup_lock = sup_lock_ff;
        nxt_drv_lock = drv_lock_ff;
        nxt_sup_flag = sup_flag_ff;
        nxt_drv_flag = drv_flag_ff;
        if (wr_hsc) begin
            nxt_hsc = reg_wdata;                                              // R16
        end
        if (wr_ssc) begin
            nxt_sup_ie = reg_wdata[hs_supply_pkg::SSC_OT_IRQ_EN];             // R5
            nxt_sup_on = reg_wdata[hs_supply_pkg::SSC_REG_ON];                // R6
        end
        // shutdown lock released only by a write while the cause is gone
        if (wr_ssc && !sup_ot) begin
            nxt_sup_lock = 1'b0;                                              // R4
        end
        if (sup_ot) begin
            nxt_sup_lock = 1'b1;                                              // R2
        end
        if (wr_hsc && !drv_ot && !ov_trip) begin
            nxt_drv_lock = 1'b0;                                              // R12 R14
        end
        if (drv_ot || ov_trip) begin
            nxt_drv_lock = 1'b1;                                              // R10
        end
        // flags: read clears, new event edge wins
        if (rd_ssc) begin
            nxt_sup_flag = 1'b0;                                              // R3
        end
        if (sup_ot && !sup_ot_d_ff) begin
            nxt_sup_flag = 1'b1;
        end
        if (rd_hss) begin
            nxt_drv_flag = 1'b0;                                              // R21
        end
        if (drv_ot && !drv_ot_d_ff) begin
            nxt_drv_flag = 1'b1;                                              // R10
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            hsc_ff      <= hs_supply_pkg::REG_RESET;
            sup_on_ff   <= 1'b0;
            sup_ie_ff   <= 1'b0;
            sup_flag_ff <= 1'b0;
            drv_flag_ff <= 1'b0;
            sup_lock_ff <= 1'b0;
            drv_lock_ff <= 1'b0;
            sup_ot_d_ff <= 1'b0;
            drv_ot_d_ff <= 1'b0;
        end else begin
            hsc_ff      <= nxt_hsc;
            sup_on_ff   <= nxt_sup_on;
            sup_ie_ff   <= nxt_sup_ie;
            sup_flag_ff <= nxt_sup_flag;
            drv_flag_ff <= nxt_drv_flag;
            sup_lock_ff <= nxt_sup_lock;
            drv_lock_ff <= nxt_drv_lock;
            sup_ot_d_ff <= nxt_sup_ot_d;
            drv_ot_d_ff <= nxt_drv_ot_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic [1:0] nxt_drv_on;
    logic [1:0] ol_stat;
    logic [7:0] nxt_rdata;
    logic       nxt_supply;

    genvar g;
    generate
        for (g = 0; g < hs_supply_pkg::NUM_DRIVERS; g++) begin : g_drv
            logic pwm_lvl;
            // modulation enable applies selected channel, else steady on
            assign pwm_lvl = hsc_ff[hs_supply_pkg::HSC_CHSEL_LSB + g]
                           ? pwm_s[1] : pwm_s[0];                             // R17
            // no power-mode gating, drivers serve cyclic sense in low power
            assign nxt_drv_on[g] = hsc_ff[hs_supply_pkg::HSC_ENABLE_LSB + g]  // R19 R15
                                 && !drv_lock_ff && !drv_ot && !ov_trip
                                 && (!hsc_ff[hs_supply_pkg::HSC_MODEN_LSB + g]
                                     || pwm_lvl);                             // R18
            // open load only reported while driver conducts
            assign ol_stat[g] = ol_s[g] && driver_on[g];                      // R7 R8
        end
    endgenerate

    always_comb begin
        nxt_supply = sup_on_ff && !sup_lock_ff && !sup_ot
                   && (power_mode == hs_supply_pkg::MODE_NORMAL);             // R1 R2
        nxt_rdata  = 8'h00;
        unique case (reg_addr)
            hs_supply_pkg::HIGH_SIDE_CONTROL_OFS: begin
                nxt_rdata = hsc_ff;
            end
            hs_supply_pkg::HIGH_SIDE_STATUS_OFS: begin
                nxt_rdata[hs_supply_pkg::HSS_OT_COND] = drv_ot;               // R11
                nxt_rdata[hs_supply_pkg::HSS_CLIM_LSB +: hs_supply_pkg::NUM_DRIVERS] = cl_s; // R9
                nxt_rdata[hs_supply_pkg::HSS_OLOAD_LSB +: hs_supply_pkg::NUM_DRIVERS] = ol_stat; // R7
            end
            hs_supply_pkg::SENSOR_SUPPLY_CONTROL_OFS: begin
                nxt_rdata[hs_supply_pkg::SSC_OT_IRQ_EN] = sup_ie_ff;          // R5
                nxt_rdata[hs_supply_pkg::SSC_OT_COND]   = sup_ot;             // R2
                nxt_rdata[hs_supply_pkg::SSC_REG_ON]    = sup_on_ff;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata            <= 8'h00;
            sensor_supply_output <= 1'b0;
            driver_on            <= 2'b00;
            supply_overtemp_irq  <= 1'b0;
            driver_overtemp_irq  <= 1'b0;
        end else begin
            reg_rdata            <= nxt_rdata;
            sensor_supply_output <= nxt_supply;
            driver_on            <= nxt_drv_on;
            supply_overtemp_irq  <= nxt_sup_flag && sup_ie_ff;                // R22
            driver_overtemp_irq  <= nxt_drv_flag
                                  && hsc_ff[hs_supply_pkg::HSC_OT_IRQ_EN];    // R22
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_sup_ot;
        sup_ot;
    endsequence

    property p_supply_normal_only;
        @(posedge mclk) disable iff (reset)
        (power_mode != hs_supply_pkg::MODE_NORMAL) |=> !sensor_supply_output;
    endproperty
    a_supply_normal_only: assert property (p_supply_normal_only) // R1
        else $error("supply on outside normal mode");

    property p_supply_ot_off;
        @(posedge mclk) disable iff (reset)
        s_sup_ot |=> !sensor_supply_output;
    endproperty
    a_supply_ot_off: assert property (p_supply_ot_off) // R2
        else $error("supply on during overtemperature");

    property p_supply_flag_read;
        @(posedge mclk) disable iff (reset)
        (rd_ssc && !(sup_ot && !sup_ot_d_ff)) |=> !sup_flag_ff;
    endproperty
    a_supply_flag_read: assert property (p_supply_flag_read) // R3
        else $error("supply flag not cleared by read");

    property p_supply_relock;
        @(posedge mclk) disable iff (reset)
        (sup_lock_ff && !wr_ssc) |=> sup_lock_ff;
    endproperty
    a_supply_relock: assert property (p_supply_relock) // R4
        else $error("supply restarted without write");

    property p_driver_ot_off;
        @(posedge mclk) disable iff (reset)
        (drv_ot || ov_trip) |=> (driver_on == 2'b00);
    endproperty
    a_driver_ot_off: assert property (p_driver_ot_off) // R10
        else $error("driver on during shutdown cause");

    property p_driver_relock;
        @(posedge mclk) disable iff (reset)
        (drv_lock_ff && !wr_hsc) |=> drv_lock_ff;
    endproperty
    a_driver_relock: assert property (p_driver_relock) // R12
        else $error("driver restarted without write");

    property p_open_load_off;
        @(posedge mclk) disable iff (reset)
        (driver_on == 2'b00 && reg_addr == hs_supply_pkg::HIGH_SIDE_STATUS_OFS)
            |=> (reg_rdata[hs_supply_pkg::HSS_OLOAD_LSB +: hs_supply_pkg::NUM_DRIVERS] == 2'b00);
    endproperty
    a_open_load_off: assert property (p_open_load_off) // R8
        else $error("open load reported while off");

    property p_irq_gate;
        @(posedge mclk) disable iff (reset)
        driver_overtemp_irq |-> $past(hsc_ff[hs_supply_pkg::HSC_OT_IRQ_EN]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) // R22
        else $error("driver irq without enable");

endmodule : high_side_and_sensor_supply_ctrl

// ==== hs_load_model.sv ====
`timescale 1ns/10ps
// ****************************************
// power stages and loads
// ****************************************
module hs_load_model (
    input  wire logic [1:0] driver_on,        // gates from block
    input  wire logic [1:0] load_present,     // load connected per driver
    input  wire logic [1:0] overload,         // short or heavy load
    output logic      [1:0] open_load_in,     // current under threshold
    output logic      [1:0] current_limit_in  // in limitation region
);
    // an off stage carries no current, so it reads as open load
    assign open_load_in     = ~(driver_on & load_present);
    assign current_limit_in = driver_on & overload;
endmodule : hs_load_model

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
    logic                       mclk, reset, reg_wr, reg_rd;
    logic [7:0]                 reg_addr, reg_wdata, reg_rdata;
    hs_supply_pkg::power_mode_e power_mode;
    logic [1:0]                 pwm_channel, open_load_in, current_limit_in, driver_on;
    logic [1:0]                 load_present, overload;
    logic                       supply_overtemp_in, driver_overtemp_in, overvoltage_condition;
    logic                       sensor_supply_output, supply_overtemp_irq, driver_overtemp_irq;
    int                         err_count, total_checks;
    logic [7:0]                 m_hsc;
    bit                         m_sie, m_son, m_hlock, m_vlock, m_slock, m_hflag, m_sflag;

    high_side_and_sensor_supply_ctrl dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .power_mode(power_mode), .pwm_channel(pwm_channel),
        .supply_overtemp_in(supply_overtemp_in), .driver_overtemp_in(driver_overtemp_in),
        .overvoltage_condition(overvoltage_condition), .open_load_in(open_load_in),
        .current_limit_in(current_limit_in), .sensor_supply_output(sensor_supply_output),
        .driver_on(driver_on), .supply_overtemp_irq(supply_overtemp_irq),
        .driver_overtemp_irq(driver_overtemp_irq));
    hs_load_model load_u (.driver_on(driver_on), .load_present(load_present),
        .overload(overload), .open_load_in(open_load_in), .current_limit_in(current_limit_in));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task close_out;
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        if (a == 8'h28) begin
            m_hsc = d;
            if (!driver_overtemp_in) m_hlock = 0;
            if (!overvoltage_condition) m_vlock = 0;
        end else if (a == 8'h38) begin
            m_sie = d[7];
            m_son = d[0];
            if (!supply_overtemp_in) m_slock = 0;
        end
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp, "read data");
        if (a == 8'h29) m_hflag = 0;
        if (a == 8'h38) m_sflag = 0;
    endtask : rd

    // rising ot latches flag and shutdown, overvoltage only shutdown if m_hsc[6]; 0 driver ot, 1 supply ot, 2 overvoltage
    task cond(input int which, input bit v);
        @(negedge mclk);
        case (which)
            0: begin
                if (v && !driver_overtemp_in) {m_hflag, m_hlock} = 2'b11;
                driver_overtemp_in = v;
            end
            1: begin
                if (v && !supply_overtemp_in) {m_sflag, m_slock} = 2'b11;
                supply_overtemp_in = v;
            end
            default: begin
                if (v && m_hsc[6]) m_vlock = 1;
                overvoltage_condition = v;
            end
        endcase
    endtask : cond

    function automatic logic [1:0] exp_drv();
        logic [1:0] d;
        for (int i = 0; i < 2; i++) begin
            d[i] = m_hsc[i] && !(m_hlock || m_vlock) && (!m_hsc[2+i] || pwm_channel[m_hsc[4+i]]);
        end
        return d;
    endfunction : exp_drv

    task check_all;
        logic [1:0] d;
        repeat (5) @(negedge mclk);
        d = exp_drv();
        chk({6'h00, driver_on}, {6'h00, d}, "driver gates");
        chk({7'h00, sensor_supply_output},
            {7'h00, m_son && !m_slock && power_mode == hs_supply_pkg::MODE_NORMAL}, "supply");
        chk({6'h00, supply_overtemp_irq, driver_overtemp_irq},
            {6'h00, m_sflag && m_sie, m_hflag && m_hsc[7]}, "irq before reads");
        rd(8'h28, m_hsc);
        rd(8'h29, {driver_overtemp_in, 3'h0, d & overload, d & ~load_present});
        rd(8'h38, {m_sie, supply_overtemp_in, 5'h00, m_son});
        rd(8'h40, 8'h00);
        chk({6'h00, supply_overtemp_irq, driver_overtemp_irq}, 8'h00, "irq after reads");
    endtask : check_all

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {err_count, total_checks} = '0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, pwm_channel, load_present, overload} = '0;
        {supply_overtemp_in, driver_overtemp_in, overvoltage_condition} = '0;
        {m_hsc, m_sie, m_son, m_hlock, m_vlock, m_slock, m_hflag, m_sflag} = '0;
        power_mode = hs_supply_pkg::MODE_NORMAL;
        reset = 1'b1;
        repeat (4) @(negedge mclk);
        reset = 1'b0;
        void'($urandom(32'h8CC0));
        check_all;
        repeat (40) begin
            wr(8'h28, 8'($urandom()));
            wr(8'h38, 8'($urandom()));
            wr(8'h29, 8'($urandom()));
            pwm_channel = 2'($urandom());
            load_present = 2'($urandom());
            overload = 2'($urandom());
            power_mode = hs_supply_pkg::power_mode_e'($urandom_range(2));
            check_all;
        end
        wr(8'h28, 8'h83);
        cond(0, 1);
        check_all;
        wr(8'h28, 8'h83);
        check_all;
        cond(0, 0);
        check_all;
        wr(8'h28, 8'h83);
        check_all;
        cond(2, 1);
        check_all;
        cond(2, 0);
        wr(8'h28, 8'h43);
        cond(2, 1);
        check_all;
        wr(8'h28, 8'h43);
        check_all;
        cond(2, 0);
        check_all;
        wr(8'h28, 8'h43);
        check_all;
        power_mode = hs_supply_pkg::MODE_NORMAL;
        wr(8'h38, 8'h81);
        cond(1, 1);
        check_all;
        wr(8'h38, 8'h81);
        cond(1, 0);
        check_all;
        wr(8'h38, 8'h81);
        check_all;
        power_mode = hs_supply_pkg::MODE_SLEEP;
        check_all;
        power_mode = hs_supply_pkg::MODE_STOP;
        check_all;
        reset = 1'b1;
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        {m_hsc, m_sie, m_son, m_hlock, m_vlock, m_slock, m_hflag, m_sflag} = '0;
        check_all;
        close_out;
    end

    initial begin
        #1_000_000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        close_out;
    end
endmodule : testbench
